// ### rtl/emc_bank.sv
`timescale 1ns/1ps
module emc_bank (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  input  wire logic       ce_i,
  // Serial pins
  input  wire logic       spi_sck_i,
  input  wire logic       spi_cs_n_i,
  input  wire logic       spi_mosi_i,
  output logic            spi_miso_o,
  output logic            spi_miso_oe_n_o,
  // Fault reports and device mode from on-chip logic
  input  wire logic       ecv_openload_i,
  input  wire logic       other_openload_i,
  input  wire logic       first_half_bridge_openload_i,
  input  wire logic       phy_error_i,
  input  wire logic       warning_i,
  input  wire logic [1:0] device_mode_i,
  // Status and configuration outputs
  output logic [7:0]      global_status_byte_o,
  output logic            pump_shutdown_o,
  output logic            can_auto_bias_o,
  output logic            direction_input_enable_o,
  output logic            second_external_input_wake_o,
  output logic            second_regulator_on_o
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic       sck_s;       // Synchronised serial clock
  logic       cs_n_s;      // Synchronised chip select
  logic       mosi_s;      // Synchronised data in
  logic       sck_d_reg;   // Previous serial clock
  logic       cs_n_d_reg;  // Previous chip select

  emc_sync #(
    .WIDTH (2),
    .INIT  (1'b0)
  ) u_sync_sck (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .ce_i      (ce_i),
    .async_i   ({spi_sck_i, spi_mosi_i}),
    .sync_o    ({sck_s, mosi_s})
  );

  emc_sync #(
    .WIDTH (1),
    .INIT  (1'b1)
  ) u_sync_cs (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .ce_i      (ce_i),
    .async_i   (spi_cs_n_i),
    .sync_o    (cs_n_s)
  );

  // Edge history for the synchronised serial clock and chip select
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sck_d_reg  <= 1'b0;
      cs_n_d_reg <= 1'b1;
    end else if (ce_i) begin
      sck_d_reg  <= sck_s;
      cs_n_d_reg <= cs_n_s;
    end
  end

  logic sck_rise;   // Sample point
  logic sck_fall;   // Shift-out point
  logic cs_start;   // Frame opens
  logic cs_end;     // Frame closes

  assign sck_rise = sck_s & ~sck_d_reg;
  assign sck_fall = ~sck_s & sck_d_reg;
  assign cs_start = ~cs_n_s & cs_n_d_reg;
  assign cs_end   = cs_n_s & ~cs_n_d_reg;

  // ----------------------------------------------------------------------
  // Registers and status
  // ----------------------------------------------------------------------
  logic [23:0] cfg_reg;        // fault_mask_and_config
  logic        pump_reg;       // Charge pump shutdown control
  logic        serial_err_reg; // Sticky serial error
  logic [7:0]  gsb_next;       // Next global status byte

  // Global status byte from live faults and masks
  always_comb begin
    gsb_next                 = 8'h00;
    gsb_next[emc_pkg::GSB_FUNC_ERR]   = ecv_openload_i | other_openload_i | first_half_bridge_openload_i;
    gsb_next[emc_pkg::GSB_SERIAL_ERR] = serial_err_reg;
    gsb_next[emc_pkg::GSB_PHY_ERR]    = phy_error_i;
    gsb_next[emc_pkg::GSB_WARNING]    = warning_i;
    gsb_next[emc_pkg::GSB_GLOBAL_ERR] =
        (ecv_openload_i & ~cfg_reg[emc_pkg::BIT_EC_OL_MASK])
      | (other_openload_i & ~cfg_reg[emc_pkg::BIT_OL_MASK])
      | first_half_bridge_openload_i
      | (serial_err_reg & ~cfg_reg[emc_pkg::BIT_SERIAL_MASK])
      | (phy_error_i & ~cfg_reg[emc_pkg::BIT_PHY_MASK])
      | (warning_i & ~cfg_reg[emc_pkg::BIT_WARN_MASK]);
  end

  // Registered status byte output
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      global_status_byte_o <= 8'h00;
    end else if (ce_i) begin
      global_status_byte_o <= gsb_next;
    end
  end

  // ----------------------------------------------------------------------
  // Frame receiver
  // ----------------------------------------------------------------------
  emc_pkg::emc_state_e state_reg;  // Receiver state
  logic [5:0]          cnt_reg;    // Bits sampled in this frame
  logic [31:0]         rx_reg;     // Incoming frame
  logic [31:0]         tx_reg;     // Outgoing frame
  logic [23:0]         rd_data;    // Read data of the addressed register
  logic [1:0]          rx_op;      // Operation code of the frame
  logic [5:0]          rx_addr;    // Address of the frame
  logic                frame_ok;   // Exactly one full frame received

  assign rx_op    = rx_reg[31:30];
  assign rx_addr  = rx_reg[29:24];
  assign frame_ok = (cnt_reg == 6'(emc_pkg::FRAME_BITS));

  // Read mux for the addressed register
  always_comb begin
    rd_data = 24'h00_0000;
    if (rx_reg[5:0] == emc_pkg::ADDR_FAULT_MASK_CFG) begin
      rd_data = cfg_reg;
    end else if (rx_reg[5:0] == emc_pkg::ADDR_PUMP_CTRL) begin
      rd_data[emc_pkg::BIT_PUMP_OFF] = pump_reg;
    end
  end

  // State sequencing: open on select, apply one cycle after close
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_reg <= emc_pkg::EMC_IDLE;
    end else if (ce_i) begin
      unique case (state_reg)
        emc_pkg::EMC_IDLE: begin
          if (cs_start) begin
            state_reg <= emc_pkg::EMC_SHIFT;
          end
        end
        emc_pkg::EMC_SHIFT: begin
          if (cs_end) begin
            state_reg <= emc_pkg::EMC_APPLY;
          end
        end
        emc_pkg::EMC_APPLY: begin
          state_reg <= emc_pkg::EMC_IDLE;
        end
        default: begin
          state_reg <= emc_pkg::EMC_IDLE;
        end
      endcase
    end
  end

  // Bit counter and receive shifter
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cnt_reg <= 6'h00;
      rx_reg  <= 32'h0000_0000;
    end else if (ce_i) begin
      if (cs_start) begin
        cnt_reg <= 6'h00;
      end else if (state_reg == emc_pkg::EMC_SHIFT && sck_rise && cnt_reg != 6'h3F) begin
        cnt_reg <= cnt_reg + 6'h01;
        rx_reg  <= {rx_reg[30:0], mosi_s};
      end
    end
  end

  // Transmit shifter: status byte first, register data after the header
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tx_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      if (cs_start) begin
        tx_reg <= {gsb_next, 24'h00_0000};
      end else if (state_reg == emc_pkg::EMC_SHIFT && sck_fall) begin
        if (cnt_reg == 6'(emc_pkg::HEADER_BITS)) begin
          tx_reg <= {rd_data, 8'h00};
        end else begin
          tx_reg <= {tx_reg[30:0], 1'b0};
        end
      end
    end
  end

  // Data out is driven only while selected
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      spi_miso_o      <= 1'b0;
      spi_miso_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      spi_miso_o      <= tx_reg[31];
      spi_miso_oe_n_o <= cs_n_s;
    end
  end

  // ----------------------------------------------------------------------
  // Register update at frame completion
  // ----------------------------------------------------------------------
  logic apply_write;  // Valid write frame has just closed

  assign apply_write = (state_reg == emc_pkg::EMC_APPLY) && frame_ok && (rx_op == emc_pkg::OP_WRITE);

  // Configuration bits change only when the write frame ends
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cfg_reg <= emc_pkg::CFG_RESET;
    end else if (ce_i) begin
      if (apply_write && rx_addr == emc_pkg::ADDR_FAULT_MASK_CFG) begin
        cfg_reg <= rx_reg[23:0] & emc_pkg::CFG_WRITE_MASK;
      end
    end
  end

  // Pump shutdown: a one is taken only while write enable is set
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pump_reg <= emc_pkg::PUMP_RESET;
    end else if (ce_i) begin
      if (apply_write && rx_addr == emc_pkg::ADDR_PUMP_CTRL) begin
        if (!rx_reg[emc_pkg::BIT_PUMP_OFF] || cfg_reg[emc_pkg::BIT_PUMP_WR_EN]) begin
          pump_reg <= rx_reg[emc_pkg::BIT_PUMP_OFF];
        end
      end
    end
  end

  // Serial error: wrong frame length sets it, read-and-clear clears; set wins
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      serial_err_reg <= 1'b0;
    end else if (ce_i) begin
      if (state_reg == emc_pkg::EMC_APPLY && !frame_ok) begin
        serial_err_reg <= 1'b1;
      end else if (state_reg == emc_pkg::EMC_APPLY && rx_op == emc_pkg::OP_READ_CLR) begin
        serial_err_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------------
  logic [1:0] reg2_mode;  // Second regulator field
  logic       reg2_on;    // Regulator enable before the output flop

  assign reg2_mode = {cfg_reg[emc_pkg::BIT_REG2_HI], cfg_reg[emc_pkg::BIT_REG2_LO]};

  // Regulator enable from field and device mode
  always_comb begin
    reg2_on = 1'b0;
    if (reg2_mode == emc_pkg::REG2_ACTIVE) begin
      reg2_on = (device_mode_i == emc_pkg::MODE_ACTIVE);
    end else if (reg2_mode == emc_pkg::REG2_ACT_STBY) begin
      reg2_on = (device_mode_i == emc_pkg::MODE_ACTIVE) || (device_mode_i == emc_pkg::MODE_REG_STBY);
    end
  end

  // Output flops for configuration controls
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pump_shutdown_o              <= emc_pkg::PUMP_RESET;
      can_auto_bias_o              <= emc_pkg::CFG_RESET[emc_pkg::BIT_AUTO_BIAS];
      direction_input_enable_o     <= emc_pkg::CFG_RESET[emc_pkg::BIT_DIR_EN];
      second_external_input_wake_o <= ~emc_pkg::CFG_RESET[emc_pkg::BIT_DIR_EN];
      second_regulator_on_o        <= 1'b0;
    end else if (ce_i) begin
      pump_shutdown_o              <= pump_reg;
      can_auto_bias_o              <= cfg_reg[emc_pkg::BIT_AUTO_BIAS];
      direction_input_enable_o     <= cfg_reg[emc_pkg::BIT_DIR_EN];
      second_external_input_wake_o <= ~cfg_reg[emc_pkg::BIT_DIR_EN];
      second_regulator_on_o        <= reg2_on;
    end
  end

endmodule

// ### rtl/emc_pkg.sv
// ----------------------------------------------------------------------
// Shared constants for the fault mask and configuration bank
// ----------------------------------------------------------------------
package emc_pkg;

  // ----------------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------------
  localparam int unsigned FRAME_BITS   = 32;            // Bits in one full frame
  localparam int unsigned HEADER_BITS  = 8;             // Operation code plus address
  localparam logic [1:0]  OP_WRITE     = 2'h0;          // Write the addressed register
  localparam logic [1:0]  OP_READ      = 2'h1;          // Read the addressed register
  localparam logic [1:0]  OP_READ_CLR  = 2'h2;          // Read and clear status

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [5:0]  ADDR_FAULT_MASK_CFG = 6'h26;  // fault_mask_and_config
  localparam logic [5:0]  ADDR_PUMP_CTRL      = 6'h27;  // Charge pump control

  // ----------------------------------------------------------------------
  // Field positions in fault_mask_and_config
  // ----------------------------------------------------------------------
  localparam int unsigned BIT_EC_OL_MASK   = 12;        // Electrochrome open-load mask
  localparam int unsigned BIT_OL_MASK      = 11;        // General open-load mask
  localparam int unsigned BIT_SERIAL_MASK  = 10;        // Serial error mask
  localparam int unsigned BIT_PHY_MASK     = 9;         // Physical layer error mask
  localparam int unsigned BIT_WARN_MASK    = 8;         // Global warning mask
  localparam int unsigned BIT_PUMP_WR_EN   = 7;         // Pump shutdown write enable
  localparam int unsigned BIT_AUTO_BIAS    = 4;         // CAN automatic biasing
  localparam int unsigned BIT_DIR_EN       = 3;         // Direction input enable
  localparam int unsigned BIT_REG2_HI      = 2;         // Second regulator mode, high
  localparam int unsigned BIT_REG2_LO      = 1;         // Second regulator mode, low
  localparam int unsigned BIT_PUMP_OFF     = 0;         // Pump shutdown in pump register

  // ----------------------------------------------------------------------
  // Reset values and writable bits
  // ----------------------------------------------------------------------
  localparam logic [23:0] CFG_RESET      = 24'h00_0088; // Pump write enable and direction set
  localparam logic [23:0] CFG_WRITE_MASK = 24'h00_1F9E; // Bits held by this bank
  localparam logic        PUMP_RESET     = 1'b0;        // Pump running after reset

  // ----------------------------------------------------------------------
  // Global status byte positions
  // ----------------------------------------------------------------------
  localparam int unsigned GSB_GLOBAL_ERR = 7;           // Global error
  localparam int unsigned GSB_SERIAL_ERR = 5;           // Serial error
  localparam int unsigned GSB_PHY_ERR    = 4;           // Physical layer error
  localparam int unsigned GSB_FUNC_ERR   = 3;           // Functional error
  localparam int unsigned GSB_WARNING    = 1;           // Global warning

  // ----------------------------------------------------------------------
  // Second regulator modes and device modes
  // ----------------------------------------------------------------------
  localparam logic [1:0] REG2_OFF        = 2'h0;        // Off in every mode
  localparam logic [1:0] REG2_ACTIVE     = 2'h1;        // On in active only
  localparam logic [1:0] REG2_ACT_STBY   = 2'h2;        // On in active and regulator standby
  localparam logic [1:0] MODE_ACTIVE     = 2'h0;        // Device active
  localparam logic [1:0] MODE_REG_STBY   = 2'h1;        // regulator_standby_mode
  localparam logic [1:0] MODE_BAT_STBY   = 2'h2;        // Battery standby

  // Frame receiver states
  typedef enum logic [2:0] {
    EMC_IDLE  = 3'b001,
    EMC_SHIFT = 3'b010,
    EMC_APPLY = 3'b100
  } emc_state_e;

endpackage

// ### rtl/emc_sync.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// ----------------------------------------------------------------------
module emc_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic        INIT  = 1'b0
) (
  input  wire logic             sys_clk_i,
  input  wire logic             reset_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;  // First stage, read only by the second

  // Two flops in a row; nothing else looks at the first
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      meta_reg <= {WIDTH{INIT}};
      sync_o   <= {WIDTH{INIT}};
    end else if (ce_i) begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule

// ### test/emc_bank_chk.sv
`timescale 1ns/1ps
// ----
// Port checker for the mask and configuration bank
// ----
module emc_bank_chk (
  input wire logic       sys_clk_i,
  input wire logic       reset_i,
  input wire logic       spi_cs_n_i,
  input wire logic       spi_miso_oe_n_o,
  input wire logic       ecv_openload_i,
  input wire logic       other_openload_i,
  input wire logic       first_half_bridge_openload_i,
  input wire logic       phy_error_i,
  input wire logic       warning_i,
  input wire logic [1:0] device_mode_i,
  input wire logic [7:0] global_status_byte_o,
  input wire logic       pump_shutdown_o,
  input wire logic       can_auto_bias_o,
  input wire logic       direction_input_enable_o,
  input wire logic       second_external_input_wake_o,
  input wire logic       second_regulator_on_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  // Battery standby held for two cycles
  sequence s_bat_stby;
    (device_mode_i == emc_pkg::MODE_BAT_STBY) [*2];
  endsequence
  // Inside a frame
  sequence s_in_frame;
    (!spi_cs_n_i) [*2];
  endsequence

  a_wake_inverse: assert property (second_external_input_wake_o == !direction_input_enable_o)
    else $error("wake use not inverse of direction enable");
  a_bridge_global: assert property (first_half_bridge_openload_i |=> global_status_byte_o[7])
    else $error("bridge open-load missing from global error");
  a_openload_func: assert property ((ecv_openload_i || other_openload_i) |=> global_status_byte_o[3])
    else $error("open-load missing from functional error");
  a_phy_status: assert property (1'b1 |=> global_status_byte_o[4] == $past(phy_error_i))
    else $error("physical error status wrong");
  a_warn_status: assert property (1'b1 |=> global_status_byte_o[1] == $past(warning_i))
    else $error("warning status wrong");
  a_global_cause: assert property (global_status_byte_o[7] |-> global_status_byte_o[5]
      || $past(global_status_byte_o[5]) || $past(ecv_openload_i || other_openload_i
      || first_half_bridge_openload_i || phy_error_i || warning_i))
    else $error("global error without a cause");
  a_reg_bat_off: assert property (s_bat_stby |=> !second_regulator_on_o)
    else $error("regulator on in battery standby");
  a_cfg_frame_hold: assert property (s_in_frame |=> $stable(can_auto_bias_o)
      && $stable(direction_input_enable_o) && $stable(pump_shutdown_o))
    else $error("configuration changed inside a frame");
  a_miso_idle_off: assert property (spi_cs_n_i [*4] |-> spi_miso_oe_n_o)
    else $error("data out driven while deselected");
  a_miso_frame_on: assert property ((!spi_cs_n_i) [*4] |-> !spi_miso_oe_n_o)
    else $error("data out not driven inside a frame");
endmodule

bind emc_bank emc_bank_chk u_chk (.*);

// ### test/emc_mcu.sv
`timescale 1ns/1ps
// ----
// Controller model on the serial pins, mode 0
// ----
module emc_mcu (
  input  wire logic sys_clk_i,
  input  wire logic spi_miso_i,
  output logic      spi_sck_o,
  output logic      spi_cs_n_o,
  output logic      spi_mosi_o
);
  // Clock stands low and select high outside frames
  initial begin
    spi_sck_o  = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = 1'b0;
  end

  // Wait a number of system clocks
  task automatic pause(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // One frame, MSB first; half is the serial half period in clocks
  task automatic xfer(input logic [31:0] tx, input int nbits, input int half, output logic [31:0] rx);
    rx = 32'h0000_0000;
    @(posedge sys_clk_i);
    spi_cs_n_o <= 1'b0;
    pause(half);
    for (int i = 0; i < nbits; i++) begin
      spi_mosi_o <= tx[31-i];
      pause(half);
      spi_sck_o <= 1'b1;
      rx = {rx[30:0], spi_miso_i};
      pause(half);
      spi_sck_o <= 1'b0;
    end
    pause(half);
    spi_cs_n_o <= 1'b1;
    spi_mosi_o <= ~spi_mosi_o; // Released line shows the inverse
    pause(8);
  endtask
endmodule

// ### test/testbench.sv
`timescale 1ns/1ps
// ----
// Self-checking bench for the mask and configuration bank
// ----
module testbench;
  logic        sys_clk_i;
  logic        reset_i;
  logic        ce_i;
  logic        sck, cs_n, mosi, miso, miso_oe_n;
  logic [4:0]  flt;      // {ecv, other, bridge, phy, warning}
  logic [1:0]  dev_mode;
  logic [7:0]  global_status_byte;
  logic        pump, bias, dir_en, wake, reg_on;
  logic [31:0] rx;
  logic [23:0] cfg, d;   // Bench copy of the register
  int          err_total, num_checks, v;

  emc_bank dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .ce_i(ce_i), .spi_sck_i(sck),
    .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_n_o(miso_oe_n),
    .ecv_openload_i(flt[4]), .other_openload_i(flt[3]), .first_half_bridge_openload_i(flt[2]),
    .phy_error_i(flt[1]), .warning_i(flt[0]), .device_mode_i(dev_mode), .global_status_byte_o(global_status_byte),
    .pump_shutdown_o(pump), .can_auto_bias_o(bias), .direction_input_enable_o(dir_en),
    .second_external_input_wake_o(wake), .second_regulator_on_o(reg_on));
  emc_mcu u_mcu (.sys_clk_i(sys_clk_i), .spi_miso_i(miso), .spi_sck_o(sck), .spi_cs_n_o(cs_n),
    .spi_mosi_o(mosi));

  // Clock, 40 ns period
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  // ----
  // Compare, report and end
  // ----
  task automatic chk_data(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_status(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Let outputs settle, sample at the falling edge
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask
  task automatic wr(input logic [5:0] a, input logic [23:0] w, input int half);
    u_mcu.xfer({emc_pkg::OP_WRITE, a, w}, 32, half, rx);
  endtask
  task automatic rd(input logic [5:0] a, output logic [23:0] r);
    u_mcu.xfer({emc_pkg::OP_READ, a, 24'h00_0000}, 32, 5, rx);
    r = rx[23:0];
  endtask

  // Expected status byte from masks, fault levels and serial error
  function automatic logic [7:0] exp_gsb(input logic [23:0] c, input logic [4:0] f, input logic se);
    logic g;
    g = (f[4] & !c[12]) | (f[3] & !c[11]) | f[2] | (f[1] & !c[9]) | (f[0] & !c[8]) | (se & !c[10]);
    return {g, 1'b0, se, f[1], f[4] | f[3] | f[2], 1'b0, f[0], 1'b0};
  endfunction
  // Expected regulator state from field and device mode
  function automatic logic exp_reg(input logic [1:0] fld, input logic [1:0] m);
    if (fld == emc_pkg::REG2_ACTIVE) return m == emc_pkg::MODE_ACTIVE;
    if (fld == emc_pkg::REG2_ACT_STBY) return m != emc_pkg::MODE_BAT_STBY;
    return 1'b0;
  endfunction

  // Hang guard
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    err_total++;
    stop_test();
  end

  // ----
  // Main sequence
  // ----
  initial begin
    reset_i = 1'b1;
    ce_i = 1'b1;
    flt = 5'h00;
    dev_mode = 2'h0;
    err_total = 0;
    num_checks = 0;
    v = $urandom(73665);
    repeat (3) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    settle(4);
    chk_status({2'h0, miso_oe_n, pump, bias, dir_en, wake, reg_on}, 8'h24);
    rd(emc_pkg::ADDR_FAULT_MASK_CFG, d);
    chk_data(d, emc_pkg::CFG_RESET);
    rd(6'h3F, d);
    chk_data(d, 24'h00_0000);
    // Random settings, all-clear and all-set corners, with bits 2:1 taken from the loop index
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 0 : (i == 5) ? 32'h00FF_FFFF : $urandom;
      v[2:1] = i[1:0];
      wr(emc_pkg::ADDR_FAULT_MASK_CFG, v[23:0], (i % 2) ? 9 : 5);
      cfg = v[23:0] & emc_pkg::CFG_WRITE_MASK;
      rd(emc_pkg::ADDR_FAULT_MASK_CFG, d);
      chk_data(d, cfg);
      chk_status({5'h00, bias, dir_en, wake}, {5'h00, cfg[4], cfg[3], !cfg[3]});
      for (int j = 0; j < 5; j++) begin
        @(posedge sys_clk_i);
        flt <= (j == 4) ? 5'h1F : 5'($urandom);
        dev_mode <= 2'(j % 3);
        settle(2);
        chk_status(global_status_byte, exp_gsb(cfg, flt, 1'b0));
        chk_status({7'h00, reg_on}, {7'h00, exp_reg(cfg[2:1], dev_mode)});
      end
    end
    @(posedge sys_clk_i);
    flt <= 5'h00;
    wr(6'h3E, 24'hFF_FFFF, 5);
    rd(emc_pkg::ADDR_FAULT_MASK_CFG, d);
    chk_data(d, cfg);
    // Pump shutdown gating
    wr(emc_pkg::ADDR_FAULT_MASK_CFG, 24'h00_0080, 5);
    wr(emc_pkg::ADDR_PUMP_CTRL, 24'h00_0001, 5);
    chk_status({7'h00, pump}, 8'h01);
    wr(emc_pkg::ADDR_FAULT_MASK_CFG, 24'h00_0000, 5);
    wr(emc_pkg::ADDR_PUMP_CTRL, 24'h00_0000, 5);
    chk_status({7'h00, pump}, 8'h00);
    wr(emc_pkg::ADDR_PUMP_CTRL, 24'h00_0001, 9);
    chk_status({7'h00, pump}, 8'h00);
    // Short frame: refused, serial error raised, then masked and cleared
    u_mcu.xfer({emc_pkg::OP_WRITE, emc_pkg::ADDR_FAULT_MASK_CFG, 24'h00_1F9E}, 31, 5, rx);
    chk_status(global_status_byte, exp_gsb(24'h00_0000, 5'h00, 1'b1));
    rd(emc_pkg::ADDR_FAULT_MASK_CFG, d);
    chk_data(d, 24'h00_0000);
    chk_status(rx[31:24], exp_gsb(24'h00_0000, 5'h00, 1'b1));
    wr(emc_pkg::ADDR_FAULT_MASK_CFG, 24'h00_0400, 5);
    chk_status(global_status_byte, exp_gsb(24'h00_0400, 5'h00, 1'b1));
    u_mcu.xfer({emc_pkg::OP_READ_CLR, emc_pkg::ADDR_FAULT_MASK_CFG, 24'h00_0000}, 32, 5, rx);
    chk_status(global_status_byte, 8'h00);
    // Second reset in mid-run
    @(posedge sys_clk_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    settle(4);
    chk_status({2'h0, miso_oe_n, pump, bias, dir_en, wake, reg_on}, 8'h24);
    rd(emc_pkg::ADDR_FAULT_MASK_CFG, d);
    chk_data(d, emc_pkg::CFG_RESET);
    stop_test();
  end
endmodule
